/* File: bench/channel_group_rate_limiter_asserts.sv */
// Port-level checker for the channel group rate limiter
`timescale 1ns/1ps
module channel_group_rate_limiter_asserts #(
   parameter logic [7:0] group_support = 8'h07  // Must match the design instance
) (
   input wire logic                           clk,
   input wire logic                           sys_rst,
   input wire logic                           s_axi_wready,
   input wire logic                           s_axi_bvalid,
   input wire logic                           s_axi_bready,
   input wire logic                           s_axi_arvalid,
   input wire logic                           s_axi_arready,
   input wire logic                           s_axi_rvalid,
   input wire logic                           s_axi_rready,
   input wire logic                           streaming_request,
   input wire channel_group_pkg::grant_class_t grant_class,
   input wire logic                           streaming_credit_avail,
   input wire logic                           unflowed_credit_avail,
   input wire logic [7:0]                     link0_group_enable_mask,
   input wire logic [7:0]                     link1_group_enable_mask
);
   import channel_group_pkg::*;
   // One clock domain, so one clocking and one reset for all
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // Depth is zero after reset, so no credit may show for two edges
   property p_stream_empty_rst;
      $fell(sys_rst) |-> !streaming_credit_avail ##1 !streaming_credit_avail;
   endproperty
   property p_unflowed_empty_rst;
      $fell(sys_rst) |-> !unflowed_credit_avail [*2];
   endproperty
   // Unflowed grant only with credit in hand
   property p_unflowed_gate;
      grant_class == cls_unflowed |-> unflowed_credit_avail;
   endproperty
   // Streaming grant needs credit and a request
   property p_stream_grant;
      grant_class == cls_streaming |-> streaming_credit_avail && $past(streaming_request);
   endproperty
   // Streaming with credit must never lose to base traffic
   property p_stream_over_base;
      grant_class == cls_base |-> !($past(streaming_request) && streaming_credit_avail);
   endproperty
   // Enabled groups are always a subset of the supported ones
   property p_mask_subset;
      ((link0_group_enable_mask | link1_group_enable_mask) & ~group_support) == 8'h00;
   endproperty
   // Link 0 mask moves only shortly after a write data handshake
   property p_mask_by_write;
      $changed(link0_group_enable_mask) |-> $past(s_axi_wready) || $past(s_axi_wready, 2)
         || $past(s_axi_wready, 3) || $past(s_axi_wready, 4);
   endproperty
   // Write responses are handed over once, then dropped; read data follows the address within 1 to 4 cycles
   property p_bvalid_once;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   property p_read_answer;
      s_axi_arvalid && s_axi_arready |-> ##[1:4] s_axi_rvalid;
   endproperty

   a_stream_empty_rst: assert property (p_stream_empty_rst) else $error("stream credit early");
   a_unflowed_empty_rst: assert property (p_unflowed_empty_rst) else $error("unflowed early");
   a_unflowed_gate: assert property (p_unflowed_gate) else $error("unflowed without credit");
   a_stream_grant: assert property (p_stream_grant) else $error("stream grant bad");
   a_stream_over_base: assert property (p_stream_over_base) else $error("base beat stream");
   a_mask_subset: assert property (p_mask_subset) else $error("unsupported group enabled");
   a_mask_by_write: assert property (p_mask_by_write) else $error("mask moved alone");
   a_bvalid_once: assert property (p_bvalid_once) else $error("bvalid repeated");
   a_read_answer: assert property (p_read_answer) else $error("read answer late");

   c_stream: cover property (grant_class == cls_streaming);
   c_unflowed: cover property (grant_class == cls_unflowed);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind channel_group_rate_limiter channel_group_rate_limiter_asserts #(
   .group_support(group_support)
) u_asserts (
   .clk, .sys_rst, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .streaming_request, .grant_class,
   .streaming_credit_avail, .unflowed_credit_avail, .link0_group_enable_mask,
   .link1_group_enable_mask
);

/* File: bench/channel_group_rate_limiter_test.sv */
// Self-checking bench for the channel group rate limiter
`timescale 1ns/1ps
module channel_group_rate_limiter_test;
   import channel_group_pkg::*;
   logic        clk = 0, sys_rst = 1, clk_en = 1;         // Clock enable on, dropped for three clocks in bucket
   logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        unflowed_request = 0, streaming_request = 0, base_request = 0;
   logic        packet_sent = 0, streaming_credit_avail, unflowed_credit_avail;
   logic [7:0]  link0_group_enable_mask, link1_group_enable_mask;
   grant_class_t grant_class;
   int          error_cnt = 0, n_compared = 0;

   // 40 MHz clock
   always #12.5 clk = ~clk;

   channel_group_rate_limiter i_dut (
      .clk, .sys_rst, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .unflowed_request,
      .streaming_request, .base_request, .packet_sent, .grant_class,
      .streaming_credit_avail, .unflowed_credit_avail, .link0_group_enable_mask,
      .link1_group_enable_mask
   );

   // Compare one value, count it, report a mismatch at once
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Print counts and verdict, then stop
   task automatic wrap_up;
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // AXI write; address and data released on their own ready, bready held until bvalid
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 0;
      chk({30'h0, s_axi_bresp}, {30'h0, resp_okay});
      // Let an edge pass so a following call never re-raises bready in this step
      @(posedge clk);
   endtask

   // AXI read with compare of data and response
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 0;
      chk(s_axi_rdata, exp);
      chk({30'h0, s_axi_rresp}, {30'h0, resp_okay});
      // Same spacing as the write, so rready is assigned once per step
      @(posedge clk);
   endtask

   // Send packets until the chosen credit flag drops; flag lags a cycle, so wait two
   task automatic drain(input bit strm, output int n);
      n = 0;
      while ((strm ? streaming_credit_avail : unflowed_credit_avail) === 1'b1 && n < 300) begin
         packet_sent <= 1;
         @(posedge clk);
         packet_sent <= 0;
         repeat (2) @(posedge clk);
         n++;
      end
   endtask

   // Fill a bucket at rate ex up to depth, freeze refill, then count the credits out.
   // Exponent 1c refills once in 2^20 clocks, far beyond this run.
   task automatic bucket(input bit strm, input logic [7:0] depth, input logic [7:0] ex,
                         input int cyc, input int lo, input int hi);
      int         n;
      logic [3:0] a;
      a = strm ? 4'h8 : 4'hc;
      wr(a, {16'h0, ex, depth});
      repeat (cyc) @(posedge clk);
      wr(a, {16'h0, 8'h1c, depth});
      // Clock enable low: these sends must not drain a single credit
      clk_en <= 0;
      packet_sent <= 1;
      repeat (3) @(posedge clk);
      clk_en <= 1;
      packet_sent <= 0;
      repeat (2) @(posedge clk);
      chk({29'h0, grant_class}, {29'h0, strm ? cls_streaming : cls_unflowed});
      drain(strm, n);
      chk(n inside {[lo:hi]} ? lo : n, lo);
      chk({29'h0, grant_class}, {29'h0, cls_base});
   endtask

   // Hang guard: the whole sequence needs well under this
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      wrap_up();
   end

   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 0;
      unflowed_request <= 1;
      streaming_request <= 1;
      base_request <= 1;
      rd(4'h0, 32'hb8000008);
      rd(4'h4, 32'h00000007);
      rd(4'h8, 32'h00010000);
      rd(4'hc, 32'h00000000);
      chk({30'h0, streaming_credit_avail, unflowed_credit_avail}, 0);
      wr(4'h0, 32'hffffffff);
      rd(4'h0, 32'hb8000008);
      wr(4'h4, 32'h00050300);
      rd(4'h5, 32'h00050307);
      chk({link0_group_enable_mask, link1_group_enable_mask}, 32'h0503);
      wr(4'h4, 32'hffffffff);
      repeat (2) @(posedge clk);
      chk({link0_group_enable_mask, link1_group_enable_mask}, 32'h0707);
      bucket(1, 8'h03, 8'h00, 20, 3, 3);
      bucket(1, 8'hff, 8'h0b, 80, 9, 12);
      bucket(0, 8'h02, 8'h00, 20, 2, 2);
      bucket(0, 8'hff, 8'h0a, 60, 14, 18);
      rd(4'h9, 32'h00011cff);
      wr(4'h8, 32'h00000005);
      repeat (10) @(posedge clk);
      chk({31'h0, streaming_credit_avail}, 1);
      sys_rst <= 1;
      repeat (6) @(posedge clk);
      sys_rst <= 0;
      @(posedge clk);
      chk({30'h0, streaming_credit_avail, unflowed_credit_avail}, 0);
      rd(4'h4, 32'h00000007);
      rd(4'h8, 32'h00010000);
      rd(4'hc, 32'h00000000);
      wrap_up();
   end
endmodule

/* File: core/channel_group_pkg.sv */
// Constants, register map and field layout for the channel group rate limiter
// What this block does
// - Capability identifier reads a fixed constant.
// - Next pointer reads zero when last.
// - Fixed type code marks channel-group capability.
// - Read-only group support mask, bit0 group0.
// - Link 0 enable mask, cleared on reset.
// - Link 1 enable mask, reserved single-link.
// - Streaming channel count code, read-only.
// - Streaming bucket refills every 2^exp x100ps.
// - Streaming packet sent drains one credit.
// - Streaming ranks high while bucket non-empty.
// - Streaming bucket starts at zero.
// - Streaming bucket capped at programmed depth.
// - Unflowed bucket refills every 2^exp x100ps.
// - Unflowed packet sent drains one credit.
// - Unflowed packets blocked when bucket empty.
// - Unflowed bucket starts at zero.
// - Unflowed bucket capped at programmed depth.
// - Interval and depth fields clear on reset.
// - Capability present beyond base/isochronous groups.
package channel_group_pkg;
   // Register byte offsets
   localparam logic [3:0] capability_header_off         = 4'h0;
   localparam logic [3:0] group_support_and_enables_off = 4'h4;
   localparam logic [3:0] streaming_limiter_config_off  = 4'h8;
   localparam logic [3:0] unflowed_limiter_config_off   = 4'hc;
   // Header field values
   localparam logic [7:0] cap_id_value        = 8'h08;
   localparam logic [4:0] cap_type_value      = 5'h17;
   localparam int         cap_type_pos        = 27;
   localparam int         cap_ptr_pos         = 8;
   // Field positions in word 1
   localparam int         support_pos         = 0;
   localparam int         link1_enable_pos    = 8;
   localparam int         link0_enable_pos    = 16;
   // Field positions in words 2 and 3
   localparam int         depth_pos           = 0;
   localparam int         exponent_pos        = 8;
   localparam int         count_code_pos      = 16;
   // Reset values
   localparam logic [7:0] enable_reset        = 8'h00;
   localparam logic [7:0] exponent_reset      = 8'h00;
   localparam logic [7:0] depth_reset         = 8'h00;
   localparam logic [7:0] bucket_reset        = 8'h00;
   // Streaming channel count codes
   localparam logic [1:0] stream_code_one     = 2'h0;
   localparam logic [1:0] stream_code_four    = 2'h1;
   localparam logic [1:0] stream_code_sixteen = 2'h2;
   // Timebase: 100 ps unit against a 25 ns clock
   localparam int         unit_ps             = 100;
   localparam int         clk_period_ps       = 25000;
   // Exponent giving one clock period: 250 x 100ps = 25ns, rounded up to 2^8
   localparam int         clk_exp             = 8;
   localparam int         ticks_w             = 40;
   // AXI responses
   localparam logic [1:0] resp_okay           = 2'h0;
   localparam logic [1:0] resp_slverr         = 2'h2;
   // Transmit arbiter class ranking
   typedef enum logic [2:0] {
      cls_none      = 3'b000,
      cls_unflowed  = 3'b001,
      cls_streaming = 3'b010,
      cls_base      = 3'b011
   } grant_class_t;
endpackage

/* File: core/channel_group_rate_limiter.sv */
// Channel group capability registers with two leaky-bucket credit limiters
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module channel_group_rate_limiter #(
   parameter logic [7:0] next_pointer       = 8'h00,  // Zero: last list entry
   parameter logic [7:0] group_support      = 8'h07,  // Groups implemented
   parameter logic [1:0] stream_count_code  = channel_group_pkg::stream_code_four,
   parameter bit         dual_link          = 1'b1
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        clk_en,
   // AXI4-Lite slave
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Transmit arbiter side
   input  wire logic        unflowed_request,
   input  wire logic        streaming_request,
   input  wire logic        base_request,
   input  wire logic        packet_sent,
   output channel_group_pkg::grant_class_t grant_class,
   output logic             streaming_credit_avail,
   output logic             unflowed_credit_avail,
   output logic [7:0]       link0_group_enable_mask,
   output logic [7:0]       link1_group_enable_mask
);
   import channel_group_pkg::*;

   // Software fields
   logic [7:0]  link0_en_q;                 // Link 0 group enables
   logic [7:0]  link1_en_q;                 // Link 1 group enables
   logic [7:0]  streaming_refill_exponent_q; // Streaming refill exponent
   logic [7:0]  streaming_bucket_depth_q;   // Streaming cap
   logic [7:0]  unflowed_refill_exponent_q; // Unflowed refill exponent
   logic [7:0]  unflowed_bucket_depth_q;    // Unflowed cap
   // Credit buckets
   logic [7:0]  streaming_credit_bucket_q;
   logic [7:0]  unflowed_credit_bucket_q;
   // Free-running timebase in clock periods
   logic [ticks_w-1:0] timebase_q;
   logic [ticks_w-1:0] timebase_d;
   // Bus channel state
   logic        aw_held_q;
   logic [3:0]  aw_addr_q;
   logic        w_held_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;

   // Merge byte lanes of a write into an old word
   function automatic logic [31:0] merge_lanes(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  strb);
      logic [31:0] r;
      r = old_w;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Refill tick decode: true when the timebase crosses a 2^exp x100ps edge.
   // Intervals shorter than one clock round up to one clock per credit.
   function automatic logic refill_tick(input logic [7:0] exponent,
                                        input logic [ticks_w-1:0] tb,
                                        input logic [ticks_w-1:0] tb_next);
      logic [7:0] sh;
      sh = 8'h00;
      if (exponent <= 8'(clk_exp)) begin
         return 1'b1;
      end
      sh = exponent - 8'(clk_exp);
      if (sh >= 8'(ticks_w)) begin
         return 1'b0;                      // Interval beyond timebase: never refills
      end
      return (tb >> sh) != (tb_next >> sh);
   endfunction

   // Register read decode, shared by the read path and the write merge
   function automatic logic [31:0] read_word(input logic [3:0] addr);
      logic [31:0] r;
      r = 32'h0000_0000;
      unique case (addr[3:2])
         2'h0: begin                                     // Header word
            r[7:0]                       = cap_id_value;
            r[cap_ptr_pos +: 8]          = next_pointer;
            r[cap_type_pos +: 5]         = cap_type_value;
         end
         2'h1: begin
            r[support_pos +: 8]          = group_support;
            r[link0_enable_pos +: 8]     = link0_en_q;
            r[link1_enable_pos +: 8]     = link1_en_q;
         end
         2'h2: begin
            r[depth_pos +: 8]            = streaming_bucket_depth_q;
            r[exponent_pos +: 8]         = streaming_refill_exponent_q;
            r[count_code_pos +: 2]       = stream_count_code;
         end
         2'h3: begin
            r[depth_pos +: 8]            = unflowed_bucket_depth_q;
            r[exponent_pos +: 8]         = unflowed_refill_exponent_q;
         end
      endcase
      return r;
   endfunction

   // Whole four-word map is decoded; addr bits 1:0 are ignored as AXI aligns
   logic        wr_fire;
   logic [31:0] wr_word;
   logic        tick_stream;
   logic        tick_unflowed;
   logic        sent_stream;
   logic        sent_unflowed;

   assign wr_fire    = aw_held_q && w_held_q && !s_axi_bvalid;
   assign wr_word    = merge_lanes(read_word(aw_addr_q), w_data_q, w_strb_q);
   assign timebase_d = timebase_q + 1'b1;
   assign tick_stream   = refill_tick(streaming_refill_exponent_q, timebase_q, timebase_d);
   assign tick_unflowed = refill_tick(unflowed_refill_exponent_q, timebase_q, timebase_d);
   assign sent_stream   = packet_sent && (grant_class == cls_streaming);
   assign sent_unflowed = packet_sent && (grant_class == cls_unflowed);

   // Write address and data channels taken independently, in either order
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         aw_held_q     <= 1'b0;
         aw_addr_q     <= 4'h0;
         w_held_q      <= 1'b0;
         w_data_q      <= 32'h0000_0000;
         w_strb_q      <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else if (clk_en) begin
         // Ready is a one-cycle pulse answering a valid with no slot held
         s_axi_awready <= s_axi_awvalid && !aw_held_q && !s_axi_awready;
         s_axi_wready  <= s_axi_wvalid && !w_held_q && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held_q <= 1'b0;
         end
      end
   end

   // Write response follows both halves
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= resp_okay;
      end else if (clk_en) begin
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= resp_okay;     // Every word decodes; RO bits ignore writes
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Writable fields; identifiers, support mask and count code stay fixed
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         link0_en_q                  <= enable_reset;
         link1_en_q                  <= enable_reset;
         streaming_refill_exponent_q <= exponent_reset;
         streaming_bucket_depth_q    <= depth_reset;
         unflowed_refill_exponent_q  <= exponent_reset;
         unflowed_bucket_depth_q     <= depth_reset;
      end else if (clk_en && wr_fire) begin
         unique case (aw_addr_q[3:2])
            2'h1: begin
               link0_en_q <= wr_word[link0_enable_pos +: 8];
               // Single-link parts keep the second mask reserved at zero
               if (dual_link) begin
                  link1_en_q <= wr_word[link1_enable_pos +: 8];
               end
            end
            2'h2: begin
               streaming_bucket_depth_q    <= wr_word[depth_pos +: 8];
               streaming_refill_exponent_q <= wr_word[exponent_pos +: 8];
            end
            2'h3: begin
               unflowed_bucket_depth_q    <= wr_word[depth_pos +: 8];
               unflowed_refill_exponent_q <= wr_word[exponent_pos +: 8];
            end
            default: begin
               // Header word is read-only
            end
         endcase
      end
   end

   // Read channel: one read at a time, answer one cycle after address
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= resp_okay;
      end else if (clk_en) begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= read_word(s_axi_araddr);
            s_axi_rresp  <= resp_okay;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Free-running timebase, one count per clock period
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         timebase_q <= '0;
      end else if (clk_en) begin
         timebase_q <= timebase_d;
      end
   end

   // Streaming bucket: refill saturates at depth, send drains to zero
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         streaming_credit_bucket_q <= bucket_reset;
      end else if (clk_en) begin
         if (tick_stream && !sent_stream) begin
            if (streaming_credit_bucket_q < streaming_bucket_depth_q) begin
               streaming_credit_bucket_q <= streaming_credit_bucket_q + 8'h01;
            end else begin
               // Depth lowered below count: clamp down to the new cap
               streaming_credit_bucket_q <= streaming_bucket_depth_q;
            end
         end else if (sent_stream && !tick_stream) begin
            if (streaming_credit_bucket_q != 8'h00) begin
               streaming_credit_bucket_q <= streaming_credit_bucket_q - 8'h01;
            end
         end
         // Tick and send together cancel out
      end
   end

   // Unflowed bucket: same scheme, gates unflowed packets outright
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         unflowed_credit_bucket_q <= bucket_reset;
      end else if (clk_en) begin
         if (tick_unflowed && !sent_unflowed) begin
            if (unflowed_credit_bucket_q < unflowed_bucket_depth_q) begin
               unflowed_credit_bucket_q <= unflowed_credit_bucket_q + 8'h01;
            end else begin
               unflowed_credit_bucket_q <= unflowed_bucket_depth_q;
            end
         end else if (sent_unflowed && !tick_unflowed) begin
            if (unflowed_credit_bucket_q != 8'h00) begin
               unflowed_credit_bucket_q <= unflowed_credit_bucket_q - 8'h01;
            end
         end
      end
   end

   // Transmit arbitration: registered grant class for the next packet.
   // Streaming without credit falls to the base/isochronous/alternate rank.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         grant_class <= cls_none;
      end else if (clk_en) begin
         if (unflowed_request && unflowed_credit_bucket_q != 8'h00) begin
            grant_class <= cls_unflowed;
         end else if (streaming_request && streaming_credit_bucket_q != 8'h00) begin
            grant_class <= cls_streaming;
         end else if (base_request || streaming_request) begin
            grant_class <= cls_base;
         end else begin
            grant_class <= cls_none;
         end
      end
   end

   // Status and mask outputs, registered
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         streaming_credit_avail  <= 1'b0;
         unflowed_credit_avail   <= 1'b0;
         link0_group_enable_mask <= enable_reset;
         link1_group_enable_mask <= enable_reset;
      end else if (clk_en) begin
         streaming_credit_avail  <= streaming_credit_bucket_q != 8'h00;
         unflowed_credit_avail   <= unflowed_credit_bucket_q != 8'h00;
         // Only supported groups may be enabled on the link
         link0_group_enable_mask <= link0_en_q & group_support;
         link1_group_enable_mask <= link1_en_q & group_support;
      end
   end
endmodule
